// >>> bst_defs.svh
// Constants for the boundary-scan test datapath.
// Assumes inclusion by bare name from the package and the design module.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH
`define BST_IR_W          6
`define BST_OP_EXTEST     6'h00
`define BST_OP_SAMPLE     6'h01
`define BST_OP_IDCODE     6'h02
`define BST_OP_HIGHZ      6'h03
`define BST_OP_RSVD_A_LO  6'h04
`define BST_OP_RSVD_A_HI  6'h2c
`define BST_OP_CAPTURE    6'h2d
`define BST_OP_RSVD_B_LO  6'h2e
`define BST_OP_RSVD_B_HI  6'h3d
`define BST_OP_CLAMP      6'h3e
`define BST_OP_BYPASS     6'h3f
`define BST_ID_W          32
`define BST_ID_LSB        1'h1
`define BST_BYP_CAPTURE   1'h0
`endif

// >>> bst_pkg.sv
// Types for the boundary-scan test datapath.
// Assumes bst_defs.svh is on the include path.
`include "bst_defs.svh"
package bst_pkg;
  // Test access port controller states
  typedef enum logic [3:0] {
    BST_RESET      = 4'h0,
    BST_IDLE       = 4'h1,
    BST_SEL_DR     = 4'h2,
    BST_CAP_DR     = 4'h3,
    BST_SHIFT_DR   = 4'h4,
    BST_EXIT1_DR   = 4'h5,
    BST_PAUSE_DR   = 4'h6,
    BST_EXIT2_DR   = 4'h7,
    BST_UPD_DR     = 4'h8,
    BST_SEL_IR     = 4'h9,
    BST_CAP_IR     = 4'ha,
    BST_SHIFT_IR   = 4'hb,
    BST_EXIT1_IR   = 4'hc,
    BST_PAUSE_IR   = 4'hd,
    BST_EXIT2_IR   = 4'he,
    BST_UPD_IR     = 4'hf
  } bst_state_e;

  // Serial pins from the test controller
  typedef struct packed {
    logic mode_sel;
    logic data_in;
  } bst_link_s;
endpackage : bst_pkg

// >>> bst_tap.sv
// Boundary-scan test datapath: TAP controller, instruction register,
// bypass, ID and boundary chain with observe, output and bidir cells.
// Assumes the test clock comes from the board controller; core side
// signals are on clock and cross into the test clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "bst_defs.svh"

// Summary of operation
// - Bypass, boundary, ID registers in parallel
// - Boundary chain selected for extest or sample
// - Extest drives output latches after IR update
// - Cells hold data in falling-edge latch
// - Input cells observe only; enables like outputs
// - Bidir pin uses enable cell plus capture
// - Enable high, no extest: capture core data
// - Enable low or extest: capture pad data
// - Instruction bits shift on rising test clock
// - Instruction takes effect at update state
// - Instruction register is six bits
// - Unselected registers leave chip undisturbed
// - Opcode 000000 selects extest
// - Opcode 000001 selects sample/preload
// - Opcode 000010 selects identification register
// - Opcode 000011 tri-states all controlled pins
// - Listed opcode ranges decode as reserved
// - Capture-IR loads pattern 101101
// - Opcode 111110 clamps pins, bypass serial
// - Opcode 111111 selects one-bit bypass
// - Extest shifted data applied at update-DR
// - Bypass bit captures zero at capture-DR
// - Controller reset makes identification current
// - Identification value LSB is one
module bst_tap
  import bst_pkg::*;
#(
  parameter int         N_IN    = 4,
  parameter int         N_OUT   = 4,
  parameter int         N_BIDIR = 4,
  parameter logic [3:0] VERSION = 4'h0,  // Arbitrary value
  parameter logic [10:0] MANUF  = 11'h2a5, // Arbitrary value
  parameter logic [15:0] PART   = 16'h1234 // Arbitrary value
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               test_clk,
  input  wire logic               test_rst_n,
  input  wire bst_link_s          link,
  output logic                    data_out,
  output logic                    data_out_oe,
  input  wire logic [N_IN-1:0]    in_pad,
  input  wire logic [N_OUT-1:0]   out_core,
  input  wire logic [N_OUT-1:0]   out_core_oe,
  output logic [N_OUT-1:0]        out_pad,
  output logic [N_OUT-1:0]        out_pad_oe,
  input  wire logic [N_BIDIR-1:0] bi_core,
  input  wire logic [N_BIDIR-1:0] bi_core_oe,
  input  wire logic [N_BIDIR-1:0] bi_pad_in,
  output logic [N_BIDIR-1:0]      bi_pad,
  output logic [N_BIDIR-1:0]      bi_pad_oe,
  output logic                    rsvd_mode
);
  // Chain: inputs, outputs, output enables, bidir enables, bidir capture
  localparam int CW = N_IN + 2 * N_OUT + 2 * N_BIDIR;
  localparam int O_OUT = N_IN;
  localparam int O_OE  = N_IN + N_OUT;
  localparam int O_BOE = N_IN + 2 * N_OUT;
  localparam int O_BD  = N_IN + 2 * N_OUT + N_BIDIR;

  bst_state_e             state_reg, state_next;
  logic [`BST_IR_W-1:0]   ir_sh_reg, ir_reg;
  logic                   byp_reg;
  logic [`BST_ID_W-1:0]   id_sh_reg;
  logic [CW-1:0]          bs_sh_reg, bs_lat_reg;
  logic [1:0]             tms_sync_reg, tdi_sync_reg;
  logic                   tdo_neg_reg, tdo_oe_neg_reg;
  logic [N_OUT-1:0]       oc_s1_reg, oc_s2_reg, oe_s1_reg, oe_s2_reg;
  logic [N_BIDIR-1:0]     bc_s1_reg, bc_s2_reg, be_s1_reg, be_s2_reg;
  logic [N_IN-1:0]        ip_s1_reg, ip_s2_reg;
  logic [N_BIDIR-1:0]     bp_s1_reg, bp_s2_reg;
  logic                   lat_tgl_reg;
  logic [2:0]             tgl_sync_reg;
  logic [CW-1:0]          lat_core_reg;
  logic [N_OUT-1:0]       out_pad_reg, out_pad_oe_reg;
  logic [N_BIDIR-1:0]     bi_pad_reg, bi_pad_oe_reg;
  logic [2:0]             mode_s1_reg, mode_s2_reg;
  logic                   rsvd_reg;

  wire logic tms = tms_sync_reg[1];
  wire logic tdi = tdi_sync_reg[1];

  // Instruction decode
  function automatic logic is_op(input logic [5:0] ir,
                                 input logic [5:0] op);
    return ir == op;
  endfunction : is_op

  wire logic op_extest = is_op(ir_reg, `BST_OP_EXTEST);
  wire logic op_sample = is_op(ir_reg, `BST_OP_SAMPLE);
  wire logic op_idcode = is_op(ir_reg, `BST_OP_IDCODE);
  wire logic op_highz  = is_op(ir_reg, `BST_OP_HIGHZ);
  wire logic op_clamp  = is_op(ir_reg, `BST_OP_CLAMP);
  wire logic op_rsvd   =
    (ir_reg >= `BST_OP_RSVD_A_LO && ir_reg <= `BST_OP_RSVD_A_HI) ||
    (ir_reg >= `BST_OP_RSVD_B_LO && ir_reg <= `BST_OP_RSVD_B_HI);
  wire logic sel_bs = op_extest | op_sample;
  wire logic sel_id = op_idcode;
  // Pins taken over by test logic
  wire logic pins_test = op_extest | op_clamp | op_highz;

  // Pin inputs from the board cross on two flops
  always_ff @(posedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h3;
    end else begin
      tms_sync_reg <= {tms_sync_reg[0], link.mode_sel};
      tdi_sync_reg <= {tdi_sync_reg[0], link.data_in};
    end
  end

  // Core signals and pad levels cross into the test clock domain
  always_ff @(posedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      oc_s1_reg <= '0;
      oc_s2_reg <= '0;
      oe_s1_reg <= '0;
      oe_s2_reg <= '0;
      bc_s1_reg <= '0;
      bc_s2_reg <= '0;
      be_s1_reg <= '0;
      be_s2_reg <= '0;
      ip_s1_reg <= '0;
      ip_s2_reg <= '0;
      bp_s1_reg <= '0;
      bp_s2_reg <= '0;
    end else begin
      oc_s1_reg <= out_core;
      oc_s2_reg <= oc_s1_reg;
      oe_s1_reg <= out_core_oe;
      oe_s2_reg <= oe_s1_reg;
      bc_s1_reg <= bi_core;
      bc_s2_reg <= bc_s1_reg;
      be_s1_reg <= bi_core_oe;
      be_s2_reg <= be_s1_reg;
      ip_s1_reg <= in_pad;
      ip_s2_reg <= ip_s1_reg;
      bp_s1_reg <= bi_pad_in;
      bp_s2_reg <= bp_s1_reg;
    end
  end

  // TAP next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BST_RESET:    state_next = tms ? BST_RESET : BST_IDLE;
      BST_IDLE:     state_next = tms ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR:   state_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR:   state_next = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: state_next = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: state_next = tms ? BST_UPD_DR : BST_PAUSE_DR;
      BST_PAUSE_DR: state_next = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: state_next = tms ? BST_UPD_DR : BST_SHIFT_DR;
      BST_UPD_DR:   state_next = tms ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR:   state_next = tms ? BST_RESET : BST_CAP_IR;
      BST_CAP_IR:   state_next = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: state_next = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: state_next = tms ? BST_UPD_IR : BST_PAUSE_IR;
      BST_PAUSE_IR: state_next = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: state_next = tms ? BST_UPD_IR : BST_SHIFT_IR;
      BST_UPD_IR:   state_next = tms ? BST_SEL_DR : BST_IDLE;
      default:      state_next = BST_RESET;
    endcase
  end

  // TAP state register
  always_ff @(posedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) state_reg <= BST_RESET;
    else             state_reg <= state_next;
  end

  // Instruction shift and update
  always_ff @(posedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      ir_sh_reg <= `BST_OP_IDCODE;
      ir_reg    <= `BST_OP_IDCODE;
    end else begin
      if (state_reg == BST_CAP_IR)
        ir_sh_reg <= `BST_OP_CAPTURE;
      else if (state_reg == BST_SHIFT_IR)
        ir_sh_reg <= {tdi, ir_sh_reg[`BST_IR_W-1:1]};
      if (state_reg == BST_RESET)
        ir_reg <= `BST_OP_IDCODE;
      else if (state_reg == BST_UPD_IR)
        ir_reg <= ir_sh_reg;
    end
  end

  // Parallel capture value for the boundary chain
  logic [CW-1:0] bs_cap;
  always_comb begin
    bs_cap = '0;
    bs_cap[N_IN-1:0] = ip_s2_reg;
    bs_cap[O_OUT +: N_OUT] = oc_s2_reg;
    bs_cap[O_OE +: N_OUT] = oe_s2_reg;
    bs_cap[O_BOE +: N_BIDIR] = be_s2_reg;
    for (int i = 0; i < N_BIDIR; i++)
      bs_cap[O_BD + i] = (be_s2_reg[i] && !op_extest)
                         ? bc_s2_reg[i]
                         : bp_s2_reg[i];
  end

  // Data registers; only the selected one shifts
  always_ff @(posedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      byp_reg   <= 1'h0;
      id_sh_reg <= '0;
      bs_sh_reg <= '0;
    end else if (state_reg == BST_CAP_DR) begin
      byp_reg   <= `BST_BYP_CAPTURE;
      id_sh_reg <= {VERSION, PART, MANUF, `BST_ID_LSB};
      if (sel_bs) bs_sh_reg <= bs_cap;
    end else if (state_reg == BST_SHIFT_DR) begin
      if (sel_bs)
        bs_sh_reg <= {tdi, bs_sh_reg[CW-1:1]};
      else if (sel_id)
        id_sh_reg <= {tdi, id_sh_reg[`BST_ID_W-1:1]};
      else
        byp_reg <= tdi;
    end
  end

  // Output latches update at update-DR on the falling edge
  always_ff @(negedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      bs_lat_reg  <= '0;
      lat_tgl_reg <= 1'h0;
    end else if (state_reg == BST_UPD_DR && sel_bs) begin
      bs_lat_reg  <= bs_sh_reg;
      lat_tgl_reg <= ~lat_tgl_reg;
    end
  end

  // Serial output mux, launched on the falling edge
  wire logic in_shift = state_reg == BST_SHIFT_DR ||
                        state_reg == BST_SHIFT_IR;
  wire logic tdo_mux =
    (state_reg == BST_SHIFT_IR) ? ir_sh_reg[0] :
    sel_bs ? bs_sh_reg[0] :
    sel_id ? id_sh_reg[0] : byp_reg;
  always_ff @(negedge test_clk or negedge test_rst_n) begin
    if (!test_rst_n) begin
      tdo_neg_reg    <= 1'h0;
      tdo_oe_neg_reg <= 1'h0;
    end else begin
      tdo_neg_reg    <= tdo_mux;
      tdo_oe_neg_reg <= in_shift;
    end
  end
  assign data_out    = tdo_neg_reg;
  assign data_out_oe = tdo_oe_neg_reg;

  // Test-domain levels cross to the core clock on two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_reg <= 3'h0;
      mode_s2_reg <= 3'h0;
    end else begin
      mode_s1_reg <= {op_highz, op_rsvd, pins_test};
      mode_s2_reg <= mode_s1_reg;
    end
  end

  // Latch word crosses by toggle; copied once it is steady
  wire logic lat_new = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_reg <= 3'h0;
      lat_core_reg <= '0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], lat_tgl_reg};
      if (lat_new) lat_core_reg <= bs_lat_reg;
    end
  end

  // Pin muxing from the core-side copy of the output latches
  wire logic use_test = mode_s2_reg[0];
  wire logic use_hz   = mode_s2_reg[2];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_pad_reg    <= '0;
      out_pad_oe_reg <= '0;
      bi_pad_reg     <= '0;
      bi_pad_oe_reg  <= '0;
      rsvd_reg       <= 1'h0;
    end else begin
      rsvd_reg <= mode_s2_reg[1];
      if (use_test && use_hz) begin
        out_pad_oe_reg <= '0;
        bi_pad_oe_reg  <= '0;
      end else if (use_test) begin
        out_pad_reg    <= lat_core_reg[O_OUT +: N_OUT];
        out_pad_oe_reg <= lat_core_reg[O_OE +: N_OUT];
        bi_pad_oe_reg  <= lat_core_reg[O_BOE +: N_BIDIR];
        bi_pad_reg     <= lat_core_reg[O_BD +: N_BIDIR];
      end else begin
        out_pad_reg    <= out_core;
        out_pad_oe_reg <= out_core_oe;
        bi_pad_reg     <= bi_core;
        bi_pad_oe_reg  <= bi_core_oe;
      end
    end
  end
  assign out_pad    = out_pad_reg;
  assign out_pad_oe = out_pad_oe_reg;
  assign bi_pad     = bi_pad_reg;
  assign bi_pad_oe  = bi_pad_oe_reg;
  assign rsvd_mode  = rsvd_reg;

  // Checks on the test clock domain
  a_ir_capture: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_CAP_IR |=> ir_sh_reg == `BST_OP_CAPTURE)
    else $error("capture pattern not loaded");
  a_ir_update: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_UPD_IR |=> ir_reg == $past(ir_sh_reg))
    else $error("instruction not updated");
  a_ir_hold: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg inside {BST_SHIFT_IR, BST_CAP_IR} |=> $stable(ir_reg))
    else $error("instruction changed early");
  a_byp_zero: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_CAP_DR |=> byp_reg == 1'h0)
    else $error("bypass not zero after capture");
  a_reset_id: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    tms [*5] |=> ##2 ir_reg == `BST_OP_IDCODE)
    else $error("idcode not current after reset");
  a_id_lsb: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_CAP_DR && sel_id |=> id_sh_reg[0] == 1'h1)
    else $error("id lsb not one");
  a_byp_shift: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_SHIFT_DR && !sel_bs && !sel_id |=> byp_reg == $past(tdi))
    else $error("bypass shift wrong");
  a_bs_quiet: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    !sel_bs |=> $stable(bs_sh_reg))
    else $error("unselected chain moved");
  a_tap_reset: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_SEL_IR && tms |=> state_reg == BST_RESET)
    else $error("tap did not reach reset");
  a_tdo_drive: assert property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_SHIFT_DR |-> data_out_oe)
    else $error("serial out not driven in shift");
  c_extest: cover property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_UPD_DR && op_extest);
  c_id_read: cover property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_SHIFT_DR && sel_id);
  c_clamp: cover property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_SHIFT_DR && op_clamp);
  c_highz: cover property (@(posedge test_clk) disable iff (!test_rst_n)
    state_reg == BST_IDLE && op_highz);
endmodule : bst_tap
`default_nettype wire

// >>> bst_ctrl_model.sv
// Behavioural board test controller for the boundary-scan datapath.
// Assumes bst_pkg is compiled first; test clock stands still between scans.
`timescale 1ns/1ps
`default_nettype none
module bst_ctrl_model
  import bst_pkg::*;
(
  output logic      test_clk,
  output logic      test_rst_n,
  output bst_link_s link,
  input  wire logic data_out,
  input  wire logic data_out_oe
);
  logic [63:0] smp;  // Serial out, one sample per rising edge
  logic [63:0] soe;  // Serial out enable, sampled alongside
  int          ns;

  // Idle levels: clock low, mode and data lines pulled up
  initial begin
    test_clk = 1'h0;
    test_rst_n = 1'h0;
    link = '1;
    smp = '0;
    soe = '0;
    ns = 0;
  end

  // One test clock period; lines change just after the falling edge
  task automatic step(input logic tms, input logic tdi);
    link.mode_sel = tms;
    link.data_in = tdi;
    #40;
    smp[ns[5:0]] = data_out;
    soe[ns[5:0]] = data_out_oe;
    ns++;
    test_clk = 1'h1;
    #40;
    test_clk = 1'h0;
  endtask : step

  // Reset by pin or by five ones, then settle in idle
  task automatic tap_reset(input logic pin);
    test_rst_n = !pin;
    repeat (5) step(1'h1, 1'h1);
    test_rst_n = 1'h1;
    repeat (3) step(1'h0, 1'h1);
  endtask : tap_reset

  // Idle to shift, nb bits LSB first, update, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int nb);
    #7;
    step(1'h1, 1'h1);
    if (ir)
      step(1'h1, 1'h1);
    repeat (2) step(1'h0, 1'h1);
    ns = 0;
    for (int i = 0; i < nb; i++)
      step(i == nb - 1, din[i]);
    step(1'h1, 1'h1);
    repeat (3) step(1'h0, 1'h1);  // Two extra edges flush the input lag
    link = '1;
  endtask : scan
endmodule : bst_ctrl_model
`default_nettype wire

// >>> bst_tb.sv
// Self-checking bench for the boundary-scan datapath.
// Assumes bst_tap, bst_pkg and bst_ctrl_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bst_pkg::*;
  localparam logic [3:0]  VER = 4'h5;     // Arbitrary value
  localparam logic [10:0] MAN = 11'h155;  // Arbitrary value
  localparam logic [15:0] PRT = 16'h0c3a; // Arbitrary value
  logic        clock, rst_n, test_clk, test_rst_n;
  logic        data_out, data_out_oe, rsvd_mode;
  bst_link_s   link;
  logic [3:0]  in_pad, out_core, out_core_oe, bi_core, bi_core_oe;
  logic [3:0]  bi_pad_in, out_pad, out_pad_oe, bi_pad, bi_pad_oe;
  logic [31:0] got, got_oe;
  int          n_mismatch, num_checks;

  // Design and board controller
  bst_tap #(.VERSION(VER), .MANUF(MAN), .PART(PRT)) DUT (
    .clock(clock), .rst_n(rst_n), .test_clk(test_clk),
    .test_rst_n(test_rst_n), .link(link), .data_out(data_out),
    .data_out_oe(data_out_oe), .in_pad(in_pad), .out_core(out_core),
    .out_core_oe(out_core_oe), .out_pad(out_pad),
    .out_pad_oe(out_pad_oe), .bi_core(bi_core), .bi_core_oe(bi_core_oe),
    .bi_pad_in(bi_pad_in), .bi_pad(bi_pad), .bi_pad_oe(bi_pad_oe),
    .rsvd_mode(rsvd_mode));
  bst_ctrl_model ctl (.test_clk(test_clk), .test_rst_n(test_rst_n),
    .link(link), .data_out(data_out), .data_out_oe(data_out_oe));

  // Core clock
  initial clock = 1'h0;
  always #5 clock = ~clock;

  // Compare and count
  task automatic check(input logic [31:0] s, e, input string m);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : check

  // Serial out of the last scan, lag of two edges removed
  task automatic rd(input int nb);
    got = '0;
    got_oe = '0;
    for (int i = 0; i < nb; i++) begin
      got[i] = ctl.smp[i + 2];
      got_oe[i] = ctl.soe[i + 2];
    end
  endtask : rd

  // Let pin updates cross into the core clock
  task automatic settle;
    repeat (10) @(negedge clock);
  endtask : settle

  // Load one instruction
  task automatic ir(input logic [5:0] op);
    ctl.scan(1'h1, {26'h0, op}, 6);
    settle;
  endtask : ir

  // Pins versus core drive
  task automatic follow(input string m);
    check({out_pad_oe, out_pad, bi_pad_oe, bi_pad},
          {out_core_oe, out_core, bi_core_oe, bi_core}, m);
  endtask : follow

  // Identification word first out after a reset
  task automatic t_ident(input logic pin);
    ctl.tap_reset(pin);
    ctl.scan(1'h0, '1, 32);
    rd(32);
    check(got, {VER, PRT, MAN, 1'h1}, "ident");
    check(got_oe, 32'hffffffff, "oe in shift");
    check(data_out_oe, 1'h0, "oe idle");
  endtask : t_ident

  // Capture pattern and one-bit bypass path
  task automatic t_irpat;
    ctl.scan(1'h1, 32'h3f, 6);
    rd(6);
    check(got, 32'h2d, "ir capture");
    ctl.scan(1'h0, 32'h5, 4);
    rd(4);
    check(got, 32'ha, "bypass");
  endtask : t_irpat

  // Snapshot of pins, then preload of safe values
  task automatic t_sample;
    @(negedge clock);
    in_pad = 4'h9;
    out_core = 4'h6;
    out_core_oe = 4'hc;
    bi_core = 4'h3;
    bi_core_oe = 4'h5;
    bi_pad_in = 4'ha;
    settle;
    follow("normal");
    ir(6'h01);
    ctl.scan(1'h0, 32'h9ff50, 20);
    rd(20);
    check(got, {12'h0, bi_core & bi_core_oe | bi_pad_in & ~bi_core_oe,
      bi_core_oe, out_core_oe, out_core, in_pad}, "sample");
    settle;
    follow("sample");
  endtask : t_sample

  // Preloaded values appear, new values land at update
  task automatic t_extest;
    ir(6'h00);
    check({out_pad_oe, out_pad, bi_pad_oe, bi_pad}, 16'hf5f9, "x hold");
    ctl.scan(1'h0, 32'h6f3a0, 20);
    rd(20);
    check(got[19:16], bi_pad_in, "x capture");
    settle;
    check({out_pad_oe, out_pad, bi_pad_oe, bi_pad}, 16'h3af6, "x upd");
  endtask : t_extest

  // All enables off, then clamp with bypass path
  task automatic t_hz_clamp;
    ir(6'h03);
    check({out_pad_oe, bi_pad_oe}, 8'h00, "highz");
    ir(6'h3e);
    check({out_pad_oe, out_pad, bi_pad_oe, bi_pad}, 16'h3af6, "clamp");
    ctl.scan(1'h0, 32'h5, 4);
    rd(4);
    check(got, 32'ha, "clamp path");
  endtask : t_hz_clamp

  // Range ends of the reserved codes, then a normal one
  task automatic t_rsvd;
    logic [5:0] tbl [5] = '{6'h04, 6'h2c, 6'h2e, 6'h3d, 6'h3f};
    for (int i = 0; i < 5; i++) begin
      ir(tbl[i]);
      check(rsvd_mode, i < 4, "reserved");
    end
  endtask : t_rsvd

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    rst_n = 1'h0;
    {in_pad, out_core, out_core_oe, bi_core, bi_core_oe, bi_pad_in} = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_n = 1'h1;
    t_ident(1'h1);
    t_irpat;
    t_sample;
    t_extest;
    t_hz_clamp;
    t_rsvd;
    t_ident(1'h0);
    results;
  end

  // Hang guard
  initial begin
    #500_000;
    n_mismatch++;
    results;
  end
endmodule : testbench
`default_nettype wire
